// File: pcs_pkg.sv
`default_nettype none
package pcs_pkg;

    // ------------------------------------------------------------
    // Offsets and widths
    // ------------------------------------------------------------
    localparam logic [11:0] PCS_CMD_STATUS_OFFSET = 12'h004;
    localparam logic [7:0] PCS_CAP_PTR_OFFSET = 8'h34;
    localparam int PCS_CFG_ADDR_W = 12;

    // ------------------------------------------------------------
    // Command field positions
    // ------------------------------------------------------------
    localparam int PCS_CMD_IO_EN_BIT = 0;
    localparam int PCS_CMD_MEM_EN_BIT = 1;
    localparam int PCS_CMD_PARITY_RSP_BIT = 6;
    localparam int PCS_CMD_SYS_ERR_BIT = 8;
    localparam int PCS_CMD_INTX_DIS_BIT = 10;
    localparam logic [15:0] PCS_CMD_WRITABLE_MASK = 16'h0543;

    // ------------------------------------------------------------
    // Status field positions (within the 32-bit word)
    // ------------------------------------------------------------
    localparam int PCS_STS_INT_PEND_BIT = 19;
    localparam int PCS_STS_CAP_LIST_BIT = 20;
    localparam int PCS_STS_SIG_ABORT_BIT = 27;
    localparam int PCS_STS_SIG_SYS_ERR_BIT = 30;
    localparam int PCS_STS_PARITY_ERR_BIT = 31;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] PCS_CMD_RESET = 16'h0000;
    localparam logic PCS_FLAG_RESET = 1'b0;
    localparam logic PCS_CAP_LIST_VALUE = 1'b1;

    // Configuration request from the link layer
    typedef struct packed {
        logic rd;
        logic wr;
        logic [PCS_CFG_ADDR_W-1:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pcs_cfg_req_t;

    // Device events raised by the transaction logic
    typedef struct packed {
        logic completer_abort;
        logic err_msg_sent;
        logic poisoned_rx;
        logic intx_pending;
    } pcs_events_t;

    // Decoded command controls
    typedef struct packed {
        logic io_space_enable;
        logic mem_space_enable;
        logic parity_resp_enable;
        logic system_error_report_enable;
        logic intx_disable;
    } pcs_ctrl_t;

endpackage
`default_nettype wire

// File: pcs_w1c_flag.sv
`timescale 1ns/1ps
`default_nettype none

module pcs_w1c_flag (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic set_i,
    input wire logic clear_i,
    output logic flag_o
);
    import pcs_pkg::*;

    logic flag_reg;

    // Sticky flag, set beats write-one clear
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            flag_reg <= PCS_FLAG_RESET;
        end else if (set_i) begin
            flag_reg <= 1'b1;
        end else if (clear_i) begin
            flag_reg <= 1'b0; // R14
        end
    end

    assign flag_o = flag_reg;
endmodule

`default_nettype wire

// File: pcs_cmd_field.sv
`timescale 1ns/1ps
`default_nettype none

module pcs_cmd_field (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic wr_i,
    input wire logic [1:0] be_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] cmd_o
);
    import pcs_pkg::*;

    logic [15:0] cmd_reg;
    logic [15:0] cmd_next;
    logic [15:0] lane_mask;

    // Byte-lane merge, only implemented bits take writes
    always_comb begin
        lane_mask = {{8{be_i[1]}}, {8{be_i[0]}}} & PCS_CMD_WRITABLE_MASK;
        cmd_next = (cmd_reg & ~lane_mask) | (wdata_i & lane_mask);
    end

    // Command storage
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            cmd_reg <= PCS_CMD_RESET;
        end else if (wr_i) begin
            cmd_reg <= cmd_next;
        end
    end

    assign cmd_o = cmd_reg & PCS_CMD_WRITABLE_MASK;
endmodule

`default_nettype wire

// File: pcs_cmd_status_regs.sv
// Summary of operation
// R1: I/O space requests ignored while command bit 0 clear; RW, resets 0.
// R2: Memory space requests ignored while command bit 1 clear; RW, resets 0.
// R3: Command bit 2 and status bits 24, 28, 29 read zero, ignore writes.
// R4: Legacy command bits 3,4,5,7,9 and status 21,23,25,26 hardwired zero.
// R5: Command bit 6 parity response enable; clear means only flag parity error.
// R6: Command bit 8 enables reporting fatal and non-fatal errors upstream.
// R7: Command bit 10 disables generation of legacy INTx messages.
// R8: Status bit 19 shows an INTx message pending internally.
// R9: Status bit 20 reads one: capability list present, pointer at 34h.
// R10: Status bit 27 set on any completer-abort completion; resets zero.
// R11: Status bit 30 set when error message sent with report enable set.
// R12: Status bit 31 set whenever a poisoned TLP is received.
// R13: Command in low half, status in high half of word at 04h.
// R14: Writing one clears a status error flag; writing zero leaves it.
// R15: Reserved command bits 15:11, status 18:16 and 22 read zero.
`timescale 1ns/1ps
`default_nettype none

module pcs_cmd_status_regs (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire pcs_pkg::pcs_cfg_req_t cfg_req_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    input wire pcs_pkg::pcs_events_t events_i,
    input wire logic io_req_i,
    input wire logic mem_req_i,
    input wire logic parity_err_i,
    input wire logic fatal_err_i,
    input wire logic nonfatal_err_i,
    input wire logic intx_assert_i,
    output logic io_accept_o,
    output logic mem_accept_o,
    output logic parity_action_o,
    output logic err_report_o,
    output logic intx_msg_o,
    output pcs_pkg::pcs_ctrl_t ctrl_o
);
    import pcs_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic hit;
    logic wr_hit;
    logic rd_hit;
    logic [15:0] cmd_value;
    logic sig_abort_flag;
    logic sig_sys_err_flag;
    logic parity_err_flag;
    logic int_pend_reg;
    logic [31:0] word_value;
    logic [31:0] rdata_reg;
    logic rvalid_reg;
    logic sys_err_set;
    logic parity_set;

    // Word match at the command and status doubleword
    assign hit = (cfg_req_i.addr[PCS_CFG_ADDR_W-1:2] == PCS_CMD_STATUS_OFFSET[PCS_CFG_ADDR_W-1:2]); // R13
    assign wr_hit = cfg_req_i.wr & hit;
    assign rd_hit = cfg_req_i.rd & hit;

    // ------------------------------------------------------------
    // Command half
    // ------------------------------------------------------------
    pcs_cmd_field u_cmd (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .wr_i(wr_hit),
        .be_i(cfg_req_i.be[1:0]),
        .wdata_i(cfg_req_i.wdata[15:0]),
        .cmd_o(cmd_value)
    ); // R1 R2 R3 R4 R15

    // Decoded controls
    assign ctrl_o.io_space_enable = cmd_value[PCS_CMD_IO_EN_BIT];
    assign ctrl_o.mem_space_enable = cmd_value[PCS_CMD_MEM_EN_BIT];
    assign ctrl_o.parity_resp_enable = cmd_value[PCS_CMD_PARITY_RSP_BIT];
    assign ctrl_o.system_error_report_enable = cmd_value[PCS_CMD_SYS_ERR_BIT];
    assign ctrl_o.intx_disable = cmd_value[PCS_CMD_INTX_DIS_BIT];

    // Gating of device responses
    assign io_accept_o = io_req_i & ctrl_o.io_space_enable; // R1
    assign mem_accept_o = mem_req_i & ctrl_o.mem_space_enable; // R2
    assign parity_action_o = parity_err_i & ctrl_o.parity_resp_enable; // R5
    assign err_report_o = (fatal_err_i | nonfatal_err_i) & ctrl_o.system_error_report_enable; // R6
    assign intx_msg_o = intx_assert_i & ~ctrl_o.intx_disable; // R7

    // ------------------------------------------------------------
    // Status half
    // ------------------------------------------------------------
    assign sys_err_set = events_i.err_msg_sent & ctrl_o.system_error_report_enable; // R11
    assign parity_set = events_i.poisoned_rx | parity_err_i; // R12 R5

    // Completer abort flag
    pcs_w1c_flag u_sig_abort (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .set_i(events_i.completer_abort), // R10
        .clear_i(wr_hit & cfg_req_i.be[3] & cfg_req_i.wdata[PCS_STS_SIG_ABORT_BIT]), // R14
        .flag_o(sig_abort_flag)
    );

    // Signalled system error flag
    pcs_w1c_flag u_sig_sys_err (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .set_i(sys_err_set),
        .clear_i(wr_hit & cfg_req_i.be[3] & cfg_req_i.wdata[PCS_STS_SIG_SYS_ERR_BIT]), // R14
        .flag_o(sig_sys_err_flag)
    );

    // Detected parity error flag
    pcs_w1c_flag u_parity_err (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .set_i(parity_set),
        .clear_i(wr_hit & cfg_req_i.be[3] & cfg_req_i.wdata[PCS_STS_PARITY_ERR_BIT]), // R14
        .flag_o(parity_err_flag)
    );

    // Interrupt pending mirror, read only
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            int_pend_reg <= PCS_FLAG_RESET;
        end else begin
            int_pend_reg <= events_i.intx_pending; // R8
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Assemble word; unlisted bits stay zero
    always_comb begin
        word_value = 32'h0000_0000; // R3 R4 R15
        word_value[15:0] = cmd_value; // R13
        word_value[PCS_STS_INT_PEND_BIT] = int_pend_reg; // R8
        word_value[PCS_STS_CAP_LIST_BIT] = PCS_CAP_LIST_VALUE; // R9
        word_value[PCS_STS_SIG_ABORT_BIT] = sig_abort_flag; // R10
        word_value[PCS_STS_SIG_SYS_ERR_BIT] = sig_sys_err_flag; // R11
        word_value[PCS_STS_PARITY_ERR_BIT] = parity_err_flag; // R12
    end

    // Registered read data, zero for other offsets
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            rdata_reg <= 32'h0000_0000;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= cfg_req_i.rd;
            if (rd_hit) begin
                rdata_reg <= word_value;
            end else if (cfg_req_i.rd) begin
                rdata_reg <= 32'h0000_0000;
            end
        end
    end

    assign cfg_rdata_o = rdata_reg;
    assign cfg_rvalid_o = rvalid_reg;
endmodule

`default_nettype wire

// File: pcs_cmd_status_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module pcs_chk (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire pcs_pkg::pcs_cfg_req_t cfg_req_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic cfg_rvalid_o,
    input wire pcs_pkg::pcs_events_t events_i,
    input wire logic io_req_i,
    input wire logic mem_req_i,
    input wire logic parity_err_i,
    input wire logic fatal_err_i,
    input wire logic nonfatal_err_i,
    input wire logic intx_assert_i,
    input wire logic io_accept_o,
    input wire logic mem_accept_o,
    input wire logic parity_action_o,
    input wire logic err_report_o,
    input wire logic intx_msg_o,
    input wire pcs_pkg::pcs_ctrl_t ctrl_o
);
    import pcs_pkg::*;
    // Read of the shared word
    wire logic hit = cfg_req_i.rd && cfg_req_i.addr[11:2] == 10'h001;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // Answer timing, fixed bits and event flags
    a_read_answer: assert property (cfg_req_i.rd |=> cfg_rvalid_o) else $error("no answer");
    a_fixed_bits: assert property (hit |=> cfg_rdata_o[20] && (cfg_rdata_o & 32'h37e7_fabc) == 32'h0)
        else $error("fixed bit wrong");
    a_abort_flag: assert property (events_i.completer_abort ##1 hit |=> cfg_rdata_o[27])
        else $error("abort flag missing");
    a_poison_flag: assert property (events_i.poisoned_rx ##1 hit |=> cfg_rdata_o[31])
        else $error("poison flag missing");
    a_pend_mirror: assert property (events_i.intx_pending ##1 hit |=> cfg_rdata_o[19])
        else $error("pending bit missing");
    // Command gating of requests
    a_io_gate: assert property (io_accept_o == (io_req_i && ctrl_o.io_space_enable))
        else $error("io gate");
    a_mem_gate: assert property (mem_accept_o == (mem_req_i && ctrl_o.mem_space_enable))
        else $error("mem gate");
    a_parity_gate: assert property (parity_action_o == (parity_err_i && ctrl_o.parity_resp_enable))
        else $error("parity gate");
    a_err_gate: assert property (err_report_o == ((fatal_err_i || nonfatal_err_i)
        && ctrl_o.system_error_report_enable)) else $error("error gate");
    a_intx_gate: assert property (intx_msg_o == (intx_assert_i && !ctrl_o.intx_disable))
        else $error("intx gate");
    // Main scenarios
    c_read: cover property (cfg_rvalid_o);
    c_abort: cover property (cfg_rvalid_o && cfg_rdata_o[27]);
    c_intx: cover property (intx_msg_o);
endmodule
bind pcs_cmd_status_regs pcs_chk u_chk (.*);
`default_nettype wire

// File: pcs_rc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Config requester
// ----
module pcs_rc_model (
    input wire logic core_clk_i,
    output var pcs_pkg::pcs_cfg_req_t cfg_req_o
);
    import pcs_pkg::*;
    initial cfg_req_o = '0;
    // One request held for its edge, then rd and wr cleared and the other lines inverted
    task automatic send(input logic r, input logic w, input logic [11:0] a, input logic [3:0] b,
        input logic [31:0] d);
        @(posedge core_clk_i);
        cfg_req_o <= '{r, w, a, b, d};
        @(posedge core_clk_i);
        cfg_req_o <= '{1'b0, 1'b0, ~a, ~b, ~d};
    endtask
endmodule
`default_nettype wire

// File: pcs_cmd_status_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench
// ----
module pcs_cmd_status_regs_tb;
    import pcs_pkg::*;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    pcs_cfg_req_t cfg_req_i;
    pcs_events_t events_i = '0;
    logic parity_err_i = 1'b0;
    logic [4:0] noise = '0;
    logic [31:0] rn, rb;
    logic [31:0] cfg_rdata_o;
    logic cfg_rvalid_o;
    logic [15:0] c;
    logic [31:0] q[$];
    integer seed = 32'h0a361d86;
    int n_fail = 0, checked = 0;
    pcs_cmd_status_regs DUT (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .cfg_req_i(cfg_req_i),
        .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .events_i(events_i), .io_req_i(noise[0]),
        .mem_req_i(noise[1]), .parity_err_i(parity_err_i), .fatal_err_i(noise[2]), .nonfatal_err_i(noise[3]),
        .intx_assert_i(noise[4]), .io_accept_o(), .mem_accept_o(), .parity_action_o(), .err_report_o(),
        .intx_msg_o(), .ctrl_o());
    pcs_rc_model m (.core_clk_i(core_clk_i), .cfg_req_o(cfg_req_i));
    // Clock and random request traffic
    always #10 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) noise <= 5'($random(seed));
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        q.push_back(e);
        m.send(1'b1, 1'b0, a, 4'h0, 32'h0);
    endtask
    task automatic wr(input logic [3:0] b, input logic [31:0] d);
        m.send(1'b0, 1'b1, 12'h004, b, d);
    endtask
    task automatic ev(input logic [4:0] v);
        @(posedge core_clk_i);
        {parity_err_i, events_i} <= v;
        @(posedge core_clk_i);
        {parity_err_i, events_i} <= {4'h0, v[0]};
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value cfg_rdata_o exp %h got %h", e, s);
        end
    endtask
    task automatic results;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Read data watcher
    always @(posedge core_clk_i) begin
        if (cfg_rvalid_o === 1'b1) chk(q.size() ? q.pop_front() : 32'hx, cfg_rdata_o);
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        rd(12'h004, 32'h0010_0000);
        m.send(1'b0, 1'b1, 12'h008, 4'hf, 32'hffff_ffff);
        rd(12'h008, 32'h0);
        rd(12'h004, 32'h0010_0000);
        wr(4'hf, 32'hffff_ffff);
        rd(12'h004, 32'h0010_0543);
        $display("reset test done");
        c = 16'h0543;
        repeat (12) begin
            rn = $random(seed);
            rb = $random(seed);
            wr(rb[3:0], rn);
            if (rb[0]) c[7:0] = rn[7:0] & PCS_CMD_WRITABLE_MASK[7:0];
            if (rb[1]) c[15:8] = rn[15:8] & PCS_CMD_WRITABLE_MASK[15:8];
            rd(12'h004, {16'h0010, c});
        end
        $display("command test done");
        wr(4'h3, 32'h0);
        ev(5'b11100);
        rd(12'h004, 32'h8810_0000);
        wr(4'hf, 32'h8800_0100);
        rd(12'h004, 32'h0010_0100);
        ev(5'b00111);
        rd(12'h004, 32'hc018_0100);
        wr(4'h7, 32'hffff_0100);
        rd(12'h004, 32'hc018_0100);
        wr(4'hf, 32'h4000_0100);
        ev(5'b00000);
        rd(12'h004, 32'h8010_0100);
        repeat (4) @(posedge core_clk_i);
        $display("event test done");
        results;
    end
    // Watchdog
    initial begin
        #100_000;
        n_fail++;
        results;
    end
endmodule
`default_nettype wire
